/* File: hw/timer_with_compare_unit.sv */
/*
  Timer/counter with a 16-bit output-compare unit behind Avalon-MM.
  Assumes a one-clock system; the external count pin is asynchronous,
  the oscillator-status and A/D-enabled inputs come from same-clock logic.
*/
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "tmr_cmp_defs.svh"

// How it works
// - count is sixteen bits in two bytes
// - run-enable bit 0 gates counting
// - bit 7 picks atomic sixteen-bit access
// - bit 6 reports system clock source
// - bits 5-4 prescale one, two, four, eight
// - bit 3 enables the auxiliary oscillator
// - bit 2 skips the extra external input register stage
// - bit 1 selects external rising edges
// - compare value checked against count in modes 0010 and 1xxx
// - match drives, clears or toggles pin
// - match sets the compare flag
// - zero compare control clears output latch
// - mode 1010 flags only, pin untouched
// - interrupt when flag and enable set
// - mode 1011 pulses special event trigger
// - special event trigger clears the count
// - trigger starts conversion if converter enabled
module timer_with_compare_unit #(
  parameter int INSTR_DIVIDE = `INSTR_DIV
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire tmr_cmp_pkg::reg_addr_t i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic i_ext_clk_pin,
  input wire logic i_sysclk_from_aux_osc,
  input wire logic i_adc_enabled,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_aux_osc_enable,
  output logic o_compare_output_pin,
  output logic o_compare_irq,
  output logic o_special_event,
  output logic o_adc_start
);
  import tmr_cmp_pkg::*;

  // the two-bit divider cannot count past four
  if (INSTR_DIVIDE < 1 || INSTR_DIVIDE > 4) begin : g_bad_divide
    $error("instruction divide must lie between 1 and 4");
  end

  logic [7:0] timer_control;
  logic [7:0] compare_control;
  count_t count;
  count_t compare_value;
  logic [7:0] high_buffer;
  logic [7:0] high_write_buffer;
  logic compare_match_flag;
  logic overflow_flag;
  logic io_latch;
  logic cmp_latch;
  logic [1:0] instr_div;
  logic [2:0] prescale_cnt;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic ext_prev2;
  logic match_prev;
  logic answered;

  // registers are written only on the low byte lane
  wire bus_req = (i_avs_read | i_avs_write) & ~answered;
  // writes land on the edge at which waitrequest is seen low
  wire wr_lane0 = i_avs_write & answered & i_avs_byteenable[0];
  wire rd_req = i_avs_read & bus_req;
  wire wr_ctrl = wr_lane0 & (i_avs_address == `OFF_TIMER_CONTROL);
  wire wr_low = wr_lane0 & (i_avs_address == `OFF_COUNT_LOW);
  wire wr_high = wr_lane0 & (i_avs_address == `OFF_COUNT_HIGH);
  wire wr_cmp_lo = wr_lane0 & (i_avs_address == `OFF_COMPARE_LOW);
  wire wr_cmp_hi = wr_lane0 & (i_avs_address == `OFF_COMPARE_HIGH);
  wire wr_cmp_ctl = wr_lane0 & (i_avs_address == `OFF_COMPARE_CONTROL);
  wire wr_status = wr_lane0 & (i_avs_address == `OFF_STATUS);
  wire wr_latch = wr_lane0 & (i_avs_address == `OFF_IO_LATCH);
  wire rd_low = rd_req & (i_avs_address == `OFF_COUNT_LOW);
  wire [7:0] wdata = i_avs_writedata[7:0];

  wire wide_access_mode = timer_control[`BIT_WIDE];
  wire timer_run_enable = timer_control[`BIT_RUN];
  wire count_source_select = timer_control[`BIT_SRC];
  wire ext_clock_sync_bypass = timer_control[`BIT_SYNC_BYP];
  wire [1:0] input_prescale_select =
    timer_control[`BIT_PS_HI:`BIT_PS_LO];
  cmp_mode_t compare_mode_select;
  assign compare_mode_select = compare_control[3:0];
  wire compare_irq_enable = compare_control[`BIT_CMP_IRQ_EN];

  // instruction clock: one pulse every INSTR_DIVIDE core clocks, four by default
  wire instr_tick = (instr_div == 2'(INSTR_DIVIDE - 1));
  // both paths pass the two-flop synchroniser; the synchronised one
  // adds one more register stage, one clock later; its edge is not aligned to instr_tick
  wire ext_edge_raw = ext_sync & ~ext_prev;
  wire ext_edge_sync = ext_prev & ~ext_prev2;
  wire ext_edge = ext_clock_sync_bypass ? ext_edge_raw
                                        : ext_edge_sync;
  wire src_tick = count_source_select ? ext_edge
                                      : instr_tick;
  wire [2:0] ps_mask = 3'((4'h1 << input_prescale_select) - 4'h1);
  wire ps_done = ((prescale_cnt & ps_mask) == ps_mask);
  wire count_tick = timer_run_enable & src_tick & ps_done;

  wire match_now = (count == compare_value);
  wire cmp_mode_on = compare_mode_select[3] |
                     (compare_mode_select == `MODE_TOGGLE);
  wire match_evt = cmp_mode_on & match_now & ~match_prev;
  wire special_evt = match_evt &
                     (compare_mode_select == `MODE_SPECIAL);
  wire count_wr = wr_low | (wr_high & ~wide_access_mode);
  // a software write in the wrap cycle wins, so no overflow then
  wire wrap_evt = count_tick & (count == 16'hffff) & ~special_evt &
                  ~count_wr;

  wire [7:0] count_high_byte = count[15:8];
  wire [7:0] count_low_byte = count[7:0];
  wire [7:0] high_read = wide_access_mode ? high_buffer
                                          : count_high_byte;
  wire [7:0] ctrl_read = {timer_control[7],
                          i_sysclk_from_aux_osc,
                          timer_control[5:0]};
  logic [7:0] rd_byte;
  always_comb begin
    unique case (i_avs_address)
      `OFF_TIMER_CONTROL: rd_byte = ctrl_read;
      `OFF_COUNT_LOW: rd_byte = count_low_byte;
      `OFF_COUNT_HIGH: rd_byte = high_read;
      `OFF_COMPARE_LOW: rd_byte = compare_value[7:0];
      `OFF_COMPARE_HIGH: rd_byte = compare_value[15:8];
      `OFF_COMPARE_CONTROL: rd_byte = compare_control;
      `OFF_STATUS: rd_byte = {6'h00, overflow_flag, compare_match_flag};
      `OFF_IO_LATCH: rd_byte = {7'h00, io_latch};
      default: rd_byte = 8'h00;
    endcase
  end

  // one wait state: every access answers on the second edge
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      answered <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
    end else begin
      answered <= bus_req;
      o_avs_waitrequest <= ~bus_req;
      if (rd_req)
        o_avs_readdata <= {24'h0, rd_byte};
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
      ext_prev2 <= 1'b0;
      instr_div <= 2'h0;
    end else begin
      ext_meta <= i_ext_clk_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      ext_prev2 <= ext_prev;
      instr_div <= instr_tick ? 2'h0 : instr_div + 2'h1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst)
      prescale_cnt <= 3'h0;
    else if (wr_low | wr_ctrl | special_evt)
      prescale_cnt <= 3'h0;
    else if (timer_run_enable & src_tick)
      prescale_cnt <= ps_done ? 3'h0 : prescale_cnt + 3'h1;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_control <= `RST_TIMER_CONTROL;
      compare_control <= `RST_COMPARE_CONTROL;
      compare_value <= 16'h0;
      io_latch <= 1'b0;
    end else begin
      if (wr_ctrl)
        timer_control <= {wdata[7], 1'b0, wdata[5:0]};
      if (wr_cmp_ctl)
        compare_control <= {3'h0, wdata[4:0]};
      if (wr_cmp_lo)
        compare_value[7:0] <= wdata;
      if (wr_cmp_hi)
        compare_value[15:8] <= wdata;
      if (wr_latch)
        io_latch <= wdata[0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      count <= 16'h0;
      high_buffer <= 8'h0;
      high_write_buffer <= 8'h0;
    end else begin
      if (rd_low)
        high_buffer <= count_high_byte;
      if (wr_high)
        high_write_buffer <= wdata;
      if (special_evt)
        count <= 16'h0;
      else if (wr_low & wide_access_mode)
        count <= {high_write_buffer, wdata};
      else if (wr_low)
        count[7:0] <= wdata;
      else if (wr_high & ~wide_access_mode)
        count[15:8] <= wdata;
      else if (count_tick)
        count <= count + 16'h1;
    end
  end

  // flags: hardware set beats a software clear in the same cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      compare_match_flag <= 1'b0;
      overflow_flag <= 1'b0;
      match_prev <= 1'b0;
    end else begin
      match_prev <= match_now;
      if (match_evt)
        compare_match_flag <= 1'b1;
      else if (wr_status & wdata[`BIT_ST_CMP_FLAG])
        compare_match_flag <= 1'b0;
      if (wrap_evt)
        overflow_flag <= 1'b1;
      else if (wr_status & wdata[`BIT_ST_OVF_FLAG])
        overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst)
      cmp_latch <= 1'b0;
    else if (wr_cmp_ctl & (wdata == 8'h00))
      cmp_latch <= 1'b0;
    else if (match_evt) begin
      unique case (compare_mode_select)
        `MODE_SET_HIGH: cmp_latch <= 1'b1;
        `MODE_SET_LOW: cmp_latch <= 1'b0;
        `MODE_TOGGLE: cmp_latch <= ~cmp_latch;
        default: cmp_latch <= cmp_latch;
      endcase
    end
  end

  // modes without a pin action let the port latch through the pin
  wire pin_driven = (compare_mode_select == `MODE_SET_HIGH) |
                    (compare_mode_select == `MODE_SET_LOW) |
                    (compare_mode_select == `MODE_TOGGLE);
  wire next_pin = pin_driven ? cmp_latch : io_latch;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_compare_output_pin <= 1'b0;
      o_compare_irq <= 1'b0;
      o_special_event <= 1'b0;
      o_adc_start <= 1'b0;
      o_aux_osc_enable <= 1'b0;
    end else begin
      o_compare_output_pin <= next_pin;
      o_compare_irq <= compare_match_flag & compare_irq_enable;
      o_special_event <= special_evt;
      o_adc_start <= special_evt & i_adc_enabled;
      o_aux_osc_enable <= timer_control[`BIT_OSC_EN];
    end
  end

  chk_special_clears_count: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    special_evt |=> (count == 16'h0))
    else $error("special event did not clear the count");

  chk_match_sets_flag: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    match_evt |=> compare_match_flag)
    else $error("match did not set compare flag");

  chk_irq_follows_flag: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (compare_match_flag & compare_irq_enable) |=> o_compare_irq)
    else $error("interrupt not raised");

  chk_stopped_holds_count: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (!timer_run_enable && !wr_low && !wr_high && !special_evt)
      |=> $stable(count))
    else $error("count moved while stopped");

  chk_adc_start_gate: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_adc_start |-> ($past(special_evt) && $past(i_adc_enabled)))
    else $error("conversion started without enabled converter");

  chk_soft_mode_pin: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (compare_mode_select == `MODE_SOFT_IRQ) ##1
      (compare_mode_select == `MODE_SOFT_IRQ)
      |-> (o_compare_output_pin == $past(io_latch)))
    else $error("pin changed in soft interrupt mode");

  chk_wrap_sets_ovf: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    wrap_evt |=> (overflow_flag && count == 16'h0))
    else $error("wrap did not flag overflow");

  chk_low_read_buffers: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    rd_low |=> (high_buffer == $past(count_high_byte)))
    else $error("high byte not buffered on low read");

  chk_clear_ctl_latch: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (wr_cmp_ctl && wdata == 8'h00) |=> !cmp_latch)
    else $error("compare latch not cleared");

  chk_bus_one_wait: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ($rose(i_avs_read | i_avs_write) && o_avs_waitrequest)
      |=> !o_avs_waitrequest)
    else $error("bus answer late");

  chk_pin_follows_latch: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    pin_driven |=> (o_compare_output_pin == $past(cmp_latch)))
    else $error("pin does not follow compare latch");

  chk_trigger_one_cycle: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_special_event |=> !o_special_event)
    else $error("special event longer than one cycle");

  chk_osc_enable_level: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_aux_osc_enable == $past(timer_control[`BIT_OSC_EN]))
    else $error("oscillator enable does not follow control");
endmodule

/* File: hw/tmr_cmp_defs.svh */
/*
  Offsets, field positions, reset values and timing for the timer with
  compare unit. Assumes a 32-bit Avalon-MM slave with word offsets.
*/
`ifndef TMR_CMP_DEFS_SVH
`define TMR_CMP_DEFS_SVH

`define OFF_TIMER_CONTROL 4'h0
`define OFF_COUNT_LOW 4'h1
`define OFF_COUNT_HIGH 4'h2
`define OFF_COMPARE_LOW 4'h3
`define OFF_COMPARE_HIGH 4'h4
`define OFF_COMPARE_CONTROL 4'h5
`define OFF_STATUS 4'h6
`define OFF_IO_LATCH 4'h7

`define BIT_RUN 0
`define BIT_SRC 1
`define BIT_SYNC_BYP 2
`define BIT_OSC_EN 3
`define BIT_PS_LO 4
`define BIT_PS_HI 5
`define BIT_SYSCLK_AUX 6
`define BIT_WIDE 7

`define BIT_CMP_IRQ_EN 4
`define BIT_ST_CMP_FLAG 0
`define BIT_ST_OVF_FLAG 1

`define RST_TIMER_CONTROL 8'h00
`define RST_COMPARE_CONTROL 8'h00

`define MODE_SET_HIGH 4'h8
`define MODE_SET_LOW 4'h9
`define MODE_TOGGLE 4'h2
`define MODE_SOFT_IRQ 4'ha
`define MODE_SPECIAL 4'hb

`define CORE_CLK_MHZ 250
`define INSTR_DIV 4

`endif

/* File: hw/tmr_cmp_pkg.sv */
/*
  Types for the timer with compare unit. Assumes tmr_cmp_defs.svh for
  all numeric constants.
*/
package tmr_cmp_pkg;
  typedef logic [3:0] reg_addr_t;
  typedef logic [15:0] count_t;
  typedef logic [3:0] cmp_mode_t;
endpackage

/* File: dv/tb_timer_with_compare_unit.sv */
/*
  Self-checking bench for the timer with compare unit.
  Assumes tmr_cmp_defs.svh and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "tmr_cmp_defs.svh"
module tb_timer_with_compare_unit;
  import tmr_cmp_pkg::*;
  typedef struct {reg_addr_t a; logic [7:0] d, e; logic [3:0] be;} row_t;
  typedef struct {cmp_mode_t m; logic en, pin, irq;} mrow_t;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic i_ext_clk_pin = 1'b0;
  logic i_sysclk_from_aux_osc = 1'b0;
  logic i_adc_enabled = 1'b0;
  reg_addr_t i_avs_address = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'h0;
  logic [31:0] o_avs_readdata, rd;
  logic o_avs_waitrequest, o_aux_osc_enable, o_compare_output_pin;
  logic o_compare_irq, o_special_event, o_adc_start;
  int num_errors = 0;
  int checked = 0;
  int n_sev = 0;
  int n_adc = 0;

  timer_with_compare_unit i_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .i_ext_clk_pin(i_ext_clk_pin),
    .i_sysclk_from_aux_osc(i_sysclk_from_aux_osc),
    .i_adc_enabled(i_adc_enabled), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_aux_osc_enable(o_aux_osc_enable),
    .o_compare_output_pin(o_compare_output_pin),
    .o_compare_irq(o_compare_irq), .o_special_event(o_special_event),
    .o_adc_start(o_adc_start));

  initial begin
    forever #2 i_core_clk = ~i_core_clk;
  end

  // pulses are counted so their one-cycle width is checked for free
  always @(posedge i_core_clk) begin
    n_sev <= n_sev + (o_special_event === 1'b1);
    n_adc <= n_adc + (o_adc_start === 1'b1);
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] e, logic [31:0] got);
    checked++;
    if (got !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(logic w, reg_addr_t a, logic [7:0] d, logic [3:0] be);
    @(posedge i_core_clk);
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= be;
    i_avs_read <= !w;
    i_avs_write <= w;
    do begin
      @(posedge i_core_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic wr(reg_addr_t a, logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rdchk(string what, reg_addr_t a, logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(what, {24'h0, e}, rd);
  endtask

  task automatic set_count(logic [7:0] h, logic [7:0] l);
    wr(`OFF_COUNT_HIGH, h);
    wr(`OFF_COUNT_LOW, l);
  endtask

  // slow edges so the synchroniser never misses one
  task automatic pulse(int n);
    repeat (n) begin
      @(posedge i_core_clk);
      i_ext_clk_pin <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      i_ext_clk_pin <= 1'b0;
      repeat (3) @(posedge i_core_clk);
    end
    repeat (8) @(posedge i_core_clk);
  endtask

  // whole run is about a thousand cycles; this is over twenty times that
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    row_t regs[6] = '{
      '{`OFF_TIMER_CONTROL, 8'hff, 8'hbf, 4'h1},
      '{`OFF_COMPARE_LOW, 8'h34, 8'h34, 4'h1},
      '{`OFF_COMPARE_LOW, 8'h77, 8'h34, 4'h0},
      '{`OFF_COMPARE_HIGH, 8'h12, 8'h12, 4'h1},
      '{`OFF_IO_LATCH, 8'h00, 8'h00, 4'h1},
      '{4'h9, 8'hff, 8'h00, 4'h1}};
    mrow_t modes[4] = '{
      '{`MODE_SET_HIGH, 1'b1, 1'b1, 1'b1},
      '{`MODE_SET_LOW, 1'b0, 1'b0, 1'b0},
      '{`MODE_TOGGLE, 1'b1, 1'b1, 1'b1},
      '{`MODE_SOFT_IRQ, 1'b1, 1'b0, 1'b1}};
    repeat (4) @(posedge i_core_clk);
    chk("wait in reset", 1, o_avs_waitrequest);
    chk("pin in reset", 0, o_compare_output_pin);
    i_rst <= 1'b0;
    rdchk("control reset", `OFF_TIMER_CONTROL, `RST_TIMER_CONTROL);
    foreach (regs[i]) begin
      bus(1'b1, regs[i].a, regs[i].d, regs[i].be);
      rdchk("register", regs[i].a, regs[i].e);
    end
    pulse(0);
    chk("osc enable on", 1, o_aux_osc_enable);
    i_sysclk_from_aux_osc <= 1'b1;
    rdchk("clock status", `OFF_TIMER_CONTROL, 8'hff);
    for (int p = 0; p < 4; p++) begin
      wr(`OFF_TIMER_CONTROL, 8'h02);
      set_count(8'h00, 8'h00);
      wr(`OFF_TIMER_CONTROL, {2'b00, 2'(p), 1'b0, 1'(p), 2'b11});
      pulse(8);
      rdchk("prescaled", `OFF_COUNT_LOW, 8'h08 >> p);
    end
    pulse(0);
    chk("osc enable off", 0, o_aux_osc_enable);
    wr(`OFF_TIMER_CONTROL, 8'h02);
    pulse(4);
    rdchk("stopped", `OFF_COUNT_LOW, 8'h01);
    set_count(8'h00, 8'h00);
    wr(`OFF_TIMER_CONTROL, 8'h01);
    pulse(50);
    wr(`OFF_TIMER_CONTROL, 8'h00);
    bus(1'b0, `OFF_COUNT_LOW, 8'h00, 4'h1);
    // about 360 cycles at one tick per four clocks, bus slack allowed
    chk("internal rate", 1, 32'(rd[7:0] > 8'd75 && rd[7:0] < 8'd95));
    set_count(8'hff, 8'hff);
    wr(`OFF_STATUS, 8'h03);
    wr(`OFF_TIMER_CONTROL, 8'h07);
    pulse(1);
    rdchk("wrap low", `OFF_COUNT_LOW, 8'h00);
    rdchk("wrap high", `OFF_COUNT_HIGH, 8'h00);
    rdchk("overflow flag", `OFF_STATUS, 8'h02);
    wr(`OFF_TIMER_CONTROL, 8'h80);
    wr(`OFF_COUNT_HIGH, 8'hab);
    rdchk("wide low", `OFF_COUNT_LOW, 8'h00);
    rdchk("deferred high", `OFF_COUNT_HIGH, 8'h00);
    wr(`OFF_COUNT_LOW, 8'hcd);
    rdchk("wide low 2", `OFF_COUNT_LOW, 8'hcd);
    rdchk("wide high", `OFF_COUNT_HIGH, 8'hab);
    wr(`OFF_TIMER_CONTROL, 8'h03);
    foreach (modes[i]) begin
      set_count(8'h12, 8'h33);
      wr(`OFF_COMPARE_CONTROL, {3'b000, modes[i].en, modes[i].m});
      wr(`OFF_STATUS, 8'h03);
      pulse(1);
      chk("pin", modes[i].pin, o_compare_output_pin);
      chk("irq", modes[i].irq, o_compare_irq);
      rdchk("match flag", `OFF_STATUS, 8'h01);
    end
    wr(`OFF_STATUS, 8'h01);
    pulse(0);
    chk("irq cleared", 0, o_compare_irq);
    wr(`OFF_IO_LATCH, 8'h01);
    wr(`OFF_COMPARE_CONTROL, 8'h00);
    wr(`OFF_COMPARE_CONTROL, {4'h0, `MODE_TOGGLE});
    pulse(0);
    chk("latch cleared", 0, o_compare_output_pin);
    rdchk("io latch kept", `OFF_IO_LATCH, 8'h01);
    for (int k = 1; k >= 0; k--) begin
      i_adc_enabled <= 1'(k);
      set_count(8'h12, 8'h33);
      wr(`OFF_COMPARE_CONTROL, {4'h0, `MODE_SPECIAL});
      pulse(1);
      rdchk("period clear", `OFF_COUNT_LOW, 8'h00);
      rdchk("period clear hi", `OFF_COUNT_HIGH, 8'h00);
    end
    chk("trigger pulses", 2, n_sev);
    chk("adc starts", 1, n_adc);
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    chk("wait in reset 2", 1, o_avs_waitrequest);
    i_rst <= 1'b0;
    // clock status input is still high across this reset
    rdchk("control reset 2", `OFF_TIMER_CONTROL,
          `RST_TIMER_CONTROL | 8'h40);
    rdchk("cmp reset", `OFF_COMPARE_CONTROL, `RST_COMPARE_CONTROL);
    report_and_stop();
  end
endmodule
